//--- pkg/rcoc_regs.svh
// Constants of the reduced core opcode compatibility decoder.
// Assumes inclusion by bare name from the package and the testbench.
`ifndef RCOC_REGS_SVH
`define RCOC_REGS_SVH

// ----------------------------------------------------------------------------
// Opcode patterns (value under mask).
// ----------------------------------------------------------------------------
`define RCOC_PROBE_MASK   16'hFFD8
`define RCOC_PROBE_VAL    16'hF548
`define RCOC_FLUSH_MASK   16'hFFE0
`define RCOC_FLUSH_VAL    16'hF500
`define RCOC_CACHE_MASK   16'hFF00
`define RCOC_CACHE_VAL    16'hF400
`define RCOC_CACHE_PUSH_BIT 5
`define RCOC_SCOPE_LSB    3
`define RCOC_FP_MASK      16'hFE00
`define RCOC_FP_VAL       16'hF200
`define RCOC_CRM_MASK     16'hFFFE
`define RCOC_CRM_VAL      16'h4E7A
`define RCOC_CRM_WR_BIT   0

// ----------------------------------------------------------------------------
// Control-register move encodings (low twelve bits of the extension word).
// ----------------------------------------------------------------------------
`define RCOC_CR_TC        12'h003
`define RCOC_CR_IWIN0     12'h004
`define RCOC_CR_IWIN1     12'h005
`define RCOC_CR_DWIN0     12'h006
`define RCOC_CR_DWIN1     12'h007
`define RCOC_CR_STATUS    12'h805
`define RCOC_CR_UROOT     12'h806
`define RCOC_CR_SROOT     12'h807

// ----------------------------------------------------------------------------
// Storage indices, reset value, page geometry, frames and vectors.
// ----------------------------------------------------------------------------
`define RCOC_IDX_TC       3'h0
`define RCOC_IDX_STATUS   3'h1
`define RCOC_IDX_IWIN0    3'h2
`define RCOC_IDX_IWIN1    3'h3
`define RCOC_IDX_DWIN0    3'h4
`define RCOC_IDX_DWIN1    3'h5
`define RCOC_CR_DEPTH     6
`define RCOC_CR_RESET     32'h0000_0000
`define RCOC_PAGE_MASK    32'hFFFF_F000
`define RCOC_LINE_MASK    32'hFFFF_FFF0
`define RCOC_FMT_NORMAL   4'h0
`define RCOC_FMT_THROW    4'h1
`define RCOC_FMT_SIX      4'h2
`define RCOC_FMT_EA       4'h3
`define RCOC_FMT_FPUNIMP  4'h4
`define RCOC_FMT_ACCESS   4'h7
`define RCOC_VEC_FLINE    8'h0B
`define RCOC_VEC_FORMAT   8'h0E

`endif

//--- pkg/rcoc_pkg.sv
// Types shared by the decoder and its control-register store.
// Assumes the constants header sits on the include path.
package rcoc_pkg;
    `include "rcoc_regs.svh"

    // Decode class of one opcode.
    typedef enum logic [2:0] {
        RCOC_CL_OTHER  = 3'b000,
        RCOC_CL_PROBE  = 3'b001,
        RCOC_CL_FLUSH  = 3'b010,
        RCOC_CL_CACHE  = 3'b011,
        RCOC_CL_FP     = 3'b100,
        RCOC_CL_CRMOVE = 3'b101
    } rcoc_class_e;

    // Scope field of the cache maintenance opcodes.
    typedef enum logic [1:0] {
        RCOC_SC_NONE = 2'b00,
        RCOC_SC_LINE = 2'b01,
        RCOC_SC_PAGE = 2'b10,
        RCOC_SC_ALL  = 2'b11
    } rcoc_scope_e;

    typedef logic [2:0]  rcoc_idx_t;
    typedef logic [31:0] rcoc_word_t;
endpackage

//--- pkg/rcoc_cr_if.sv
// Carrier between the decoder and its control-register store.
// Assumes one clock shared by both ends.
interface rcoc_cr_if;
    import rcoc_pkg::*;
    logic       wen;    // Write strobe.
    rcoc_idx_t  idx;    // Storage index.
    rcoc_word_t wdata;  // Write data.
    rcoc_word_t rdata;  // Registered read data.
    modport master (output wen, output idx, output wdata, input rdata);
    modport store  (input wen, input idx, input wdata, output rdata);
endinterface

//--- verilog/rcoc_cr_store.sv
// Small memory holding the access control unit registers.
// Assumes the decoder drives one access per cycle; read data are registered.
module rcoc_cr_store
    import rcoc_pkg::*;
(
    input  wire logic   CLK,   // Core clock.
    input  wire logic   SRST,  // Synchronous reset, active high.
    rcoc_cr_if.store    cr     // Access port.
);
    rcoc_word_t mem [`RCOC_CR_DEPTH];
    rcoc_word_t next_mem [`RCOC_CR_DEPTH];
    rcoc_word_t next_rdata;

    // ------------------------------------------------------------------------
    // Next values: read the old contents first, then write.
    // ------------------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < `RCOC_CR_DEPTH; i++) begin
            next_mem[i] = mem[i];
        end
        next_rdata = `RCOC_CR_RESET;
        if (int'(cr.idx) < `RCOC_CR_DEPTH) begin
            next_rdata = mem[cr.idx];
            if (cr.wen) begin
                next_mem[cr.idx] = cr.wdata;
            end
        end
    end

    // Registers; read data come out of a flop so the top drives them directly.
    always_ff @(posedge CLK) begin
        if (SRST) begin
            for (int i = 0; i < `RCOC_CR_DEPTH; i++) begin
                mem[i] <= `RCOC_CR_RESET;
            end
            cr.rdata <= `RCOC_CR_RESET;
        end else begin
            mem      <= next_mem;
            cr.rdata <= next_rdata;
        end
    end
endmodule

//--- verilog/rcoc_decoder.sv
// Opcode compatibility decoder of a reduced core without paging unit or FPU.
// Assumes opcode, extension word and operands come from same-clock pipeline logic.
//
// Function
// [RL1] Translation probe and flush opcodes decode without raising any exception.
// [RL2] Software should avoid probe and flush; results are spurious or undefined.
// [RL3] Page-scope cache push and invalidate act on an aligned 4 Kbyte block.
// [RL4] Moves to user or supervisor root pointer are invalid and undefined.
// [RL5] Access control unit has status and translation control registers at those encodings.
// [RL6] Status register writes are accepted but never change access control behaviour.
// [RL7] Instruction and data window encodings reach the instruction and data window registers.
// [RL8] Every floating point opcode is invalid and raises the unimplemented FP exception.
// [RL9] That exception pushes a stack frame with format code 4.
// [RL10] The core never builds an exception frame of format code 3.
// [RL11] Exception return accepts a format 3 frame without a format error.
module rcoc_decoder
    import rcoc_pkg::*;
(
    input  wire logic        CLK,          // Core clock, 200 MHz.
    input  wire logic        SRST,         // Synchronous reset, active high.
    input  wire logic        OP_VALID,     // Opcode present this cycle.
    input  wire logic [15:0] OP_WORD,      // First opcode word.
    input  wire logic [15:0] OP_EXT,       // Extension word of a register move.
    input  wire logic [31:0] OP_DATA,      // General register operand.
    input  wire logic        RTE_VALID,    // Exception return presents a frame.
    input  wire logic [3:0]  RTE_FORMAT,   // Format code of that frame.
    output logic             DEC_DONE,     // Opcode decoded, pulse.
    output logic             EXC_VALID,    // Exception raised, pulse.
    output logic [7:0]       EXC_VECTOR,   // Vector of the exception.
    output logic [3:0]       EXC_FORMAT,   // Frame format to push.
    output logic             CACHE_VALID,  // Cache maintenance request, pulse.
    output logic             CACHE_PUSH,   // Push rather than invalidate.
    output logic [1:0]       CACHE_SCOPE,  // Line, page or all.
    output logic [31:0]      CACHE_BASE,   // Aligned base address.
    output logic             CR_HIT,       // Register move reached storage.
    output logic [2:0]       CR_SEL,       // Storage index reached.
    output logic [31:0]      CR_RDATA,     // Old register contents.
    output logic             UNDEF_OP,     // Undefined-outcome opcode seen.
    output logic             RTE_DONE,     // Frame judged, pulse.
    output logic             RTE_ERROR     // Format error on return.
);
    rcoc_cr_if cr ();

    rcoc_cr_store u_store (
        .CLK  (CLK),
        .SRST (SRST),
        .cr   (cr)
    );

    // ------------------------------------------------------------------------
    // Decode helpers.
    // ------------------------------------------------------------------------
    function automatic rcoc_class_e classify(input logic [15:0] w);
        if ((w & `RCOC_PROBE_MASK) == `RCOC_PROBE_VAL) return RCOC_CL_PROBE;
        if ((w & `RCOC_FLUSH_MASK) == `RCOC_FLUSH_VAL) return RCOC_CL_FLUSH;
        if ((w & `RCOC_CACHE_MASK) == `RCOC_CACHE_VAL) return RCOC_CL_CACHE;
        if ((w & `RCOC_FP_MASK) == `RCOC_FP_VAL)       return RCOC_CL_FP;
        if ((w & `RCOC_CRM_MASK) == `RCOC_CRM_VAL)     return RCOC_CL_CRMOVE;
        return RCOC_CL_OTHER;
    endfunction

    // Maps a move encoding to a storage index; the status encoding maps too.
    function automatic logic [3:0] cr_map(input logic [11:0] code);
        case (code)
            `RCOC_CR_TC:     cr_map = {1'b1, `RCOC_IDX_TC};     // [RL5]
            `RCOC_CR_STATUS: cr_map = {1'b1, `RCOC_IDX_STATUS}; // [RL5] [RL6]
            `RCOC_CR_IWIN0:  cr_map = {1'b1, `RCOC_IDX_IWIN0};  // [RL7]
            `RCOC_CR_IWIN1:  cr_map = {1'b1, `RCOC_IDX_IWIN1};  // [RL7]
            `RCOC_CR_DWIN0:  cr_map = {1'b1, `RCOC_IDX_DWIN0};  // [RL7]
            `RCOC_CR_DWIN1:  cr_map = {1'b1, `RCOC_IDX_DWIN1};  // [RL7]
            default:         cr_map = 4'h0;
        endcase
    endfunction

    function automatic logic frame_ok(input logic [3:0] f);
        return f == `RCOC_FMT_NORMAL || f == `RCOC_FMT_THROW || f == `RCOC_FMT_SIX ||
               f == `RCOC_FMT_EA || f == `RCOC_FMT_FPUNIMP || f == `RCOC_FMT_ACCESS;
    endfunction

    rcoc_class_e cls;
    rcoc_scope_e scope;
    logic [3:0]  map;
    logic        next_done, next_exc, next_cvalid, next_cache_push_op, next_hit, next_undef;
    logic        next_rte_done, next_rte_err;
    logic [7:0]  next_vec;
    logic [3:0]  next_fmt;
    logic [1:0]  next_scope;
    logic [31:0] next_base;
    logic [2:0]  next_sel;

    // ------------------------------------------------------------------------
    // Next values of the decode outputs and the store access.
    // ------------------------------------------------------------------------
    always_comb begin
        cls           = classify(OP_WORD);
        scope         = rcoc_scope_e'(OP_WORD[`RCOC_SCOPE_LSB +: 2]);
        map           = cr_map(OP_EXT[11:0]);
        next_done     = OP_VALID;
        next_exc      = 1'b0;
        next_vec      = 8'h00;
        next_fmt      = `RCOC_FMT_NORMAL;
        next_cvalid   = 1'b0;
        next_cache_push_op    = 1'b0;
        next_scope    = RCOC_SC_NONE;
        next_base     = 32'h0000_0000;
        next_hit      = 1'b0;
        next_sel      = map[2:0];
        next_undef    = 1'b0;
        cr.wen        = 1'b0;
        cr.idx        = map[2:0];
        cr.wdata      = OP_DATA;
        if (OP_VALID) begin
            case (cls)
                // No trap; the result is merely unreliable, so software is warned.
                RCOC_CL_PROBE, RCOC_CL_FLUSH: begin
                    next_undef = 1'b1; // [RL1] [RL2]
                end
                RCOC_CL_CACHE: begin
                    next_cvalid = scope != RCOC_SC_NONE;
                    next_cache_push_op  = OP_WORD[`RCOC_CACHE_PUSH_BIT];
                    next_scope  = scope;
                    if (scope == RCOC_SC_PAGE) begin
                        next_base = OP_DATA & `RCOC_PAGE_MASK; // [RL3]
                    end else if (scope == RCOC_SC_LINE) begin
                        next_base = OP_DATA & `RCOC_LINE_MASK;
                    end
                end
                RCOC_CL_FP: begin
                    next_exc = 1'b1;                  // [RL8]
                    next_vec = `RCOC_VEC_FLINE;       // [RL8]
                    next_fmt = `RCOC_FMT_FPUNIMP;     // [RL9] [RL10]
                end
                RCOC_CL_CRMOVE: begin
                    // Root pointers have no storage; the move does nothing defined.
                    if (OP_EXT[11:0] == `RCOC_CR_UROOT || OP_EXT[11:0] == `RCOC_CR_SROOT) begin
                        next_undef = 1'b1; // [RL4]
                    end
                    next_hit = map[3];
                    cr.wen   = map[3] & OP_WORD[`RCOC_CRM_WR_BIT]; // [RL6] [RL7]
                end
                default: begin
                    next_done = 1'b1;
                end
            endcase
        end
        next_rte_done = RTE_VALID;
        next_rte_err  = RTE_VALID & ~frame_ok(RTE_FORMAT); // [RL11]
    end

    // Output registers; every top output comes straight from here or the store.
    always_ff @(posedge CLK) begin
        if (SRST) begin
            DEC_DONE    <= 1'b0;
            EXC_VALID   <= 1'b0;
            EXC_VECTOR  <= 8'h00;
            EXC_FORMAT  <= `RCOC_FMT_NORMAL;
            CACHE_VALID <= 1'b0;
            CACHE_PUSH  <= 1'b0;
            CACHE_SCOPE <= RCOC_SC_NONE;
            CACHE_BASE  <= 32'h0000_0000;
            CR_HIT      <= 1'b0;
            CR_SEL      <= 3'h0;
            UNDEF_OP    <= 1'b0;
            RTE_DONE    <= 1'b0;
            RTE_ERROR   <= 1'b0;
        end else begin
            DEC_DONE    <= next_done;
            EXC_VALID   <= next_exc;
            EXC_VECTOR  <= next_vec;
            EXC_FORMAT  <= next_fmt;
            CACHE_VALID <= next_cvalid;
            CACHE_PUSH  <= next_cache_push_op;
            CACHE_SCOPE <= next_scope;
            CACHE_BASE  <= next_base;
            CR_HIT      <= next_hit;
            CR_SEL      <= next_sel;
            UNDEF_OP    <= next_undef;
            RTE_DONE    <= next_rte_done;
            RTE_ERROR   <= next_rte_err;
        end
    end

    assign CR_RDATA = cr.rdata;

    // ------------------------------------------------------------------------
    // Assertions and covers.
    // ------------------------------------------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SRST);

    probe_no_trap_a: assert property ( // [RL1]
        OP_VALID && (classify(OP_WORD) == RCOC_CL_PROBE || classify(OP_WORD) == RCOC_CL_FLUSH)
        |=> !EXC_VALID && UNDEF_OP && DEC_DONE)
        else $error("Probe or flush raised an exception.");

    page_align_a: assert property ( // [RL3]
        CACHE_VALID && CACHE_SCOPE == RCOC_SC_PAGE
        |-> CACHE_BASE == ($past(OP_DATA) & `RCOC_PAGE_MASK) && CACHE_BASE[11:0] == 12'h000)
        else $error("Page maintenance base is not the aligned block.");

    root_undef_a: assert property ( // [RL4]
        OP_VALID && classify(OP_WORD) == RCOC_CL_CRMOVE &&
        (OP_EXT[11:0] == `RCOC_CR_UROOT || OP_EXT[11:0] == `RCOC_CR_SROOT)
        |=> UNDEF_OP && !CR_HIT && !EXC_VALID)
        else $error("Root pointer move was not flagged undefined.");

    status_store_a: assert property ( // [RL5] [RL6]
        OP_VALID && classify(OP_WORD) == RCOC_CL_CRMOVE && OP_WORD[0] &&
        OP_EXT[11:0] == `RCOC_CR_STATUS
        ##1 OP_VALID && classify(OP_WORD) == RCOC_CL_CRMOVE && !OP_WORD[0] &&
        OP_EXT[11:0] == `RCOC_CR_STATUS
        |=> CR_HIT && CR_SEL == `RCOC_IDX_STATUS && CR_RDATA == $past(OP_DATA, 2))
        else $error("Status register write was not held.");

    window_map_a: assert property ( // [RL7]
        OP_VALID && classify(OP_WORD) == RCOC_CL_CRMOVE && OP_EXT[11:0] == `RCOC_CR_DWIN1
        |=> CR_HIT && CR_SEL == `RCOC_IDX_DWIN1)
        else $error("Data window encoding missed its register.");

    fp_trap_a: assert property ( // [RL8] [RL9]
        OP_VALID && classify(OP_WORD) == RCOC_CL_FP
        |=> EXC_VALID && EXC_VECTOR == `RCOC_VEC_FLINE && EXC_FORMAT == `RCOC_FMT_FPUNIMP)
        else $error("Floating point opcode did not trap with format 4.");

    no_frame_three_a: assert property ( // [RL10]
        EXC_VALID |-> EXC_FORMAT != `RCOC_FMT_EA)
        else $error("Format 3 frame was built.");

    rte_accept_a: assert property ( // [RL11]
        RTE_VALID && RTE_FORMAT == `RCOC_FMT_EA |=> RTE_DONE && !RTE_ERROR)
        else $error("Format 3 frame was refused on return.");

    fp_trap_c: cover property (OP_VALID && classify(OP_WORD) == RCOC_CL_FP ##1 EXC_VALID);
    page_op_c: cover property (CACHE_VALID && CACHE_SCOPE == RCOC_SC_PAGE && CACHE_PUSH);
    rte_three_c: cover property (RTE_VALID && RTE_FORMAT == `RCOC_FMT_EA ##1 RTE_DONE);
    window_rd_c: cover property (CR_HIT && CR_SEL == `RCOC_IDX_IWIN0);
endmodule

//--- dv/reduced_core_opcode_compat_tb.sv
// Self-checking bench of the reduced core opcode compatibility decoder.
// Assumes the decoder holds its own control-register store behind plain ports.
`include "rcoc_regs.svh"

module reduced_core_opcode_compat_tb
    import rcoc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------------------
    // Signals, model state and counters.
    // ------------------------------------------------------------------------
    logic        CLK        = 1'b0;
    logic        SRST       = 1'b1;
    logic        OP_VALID   = 1'b0;
    logic [15:0] OP_WORD    = 16'h0000;
    logic [15:0] OP_EXT     = 16'h0000;
    logic [31:0] OP_DATA    = 32'h0000_0000;
    logic        RTE_VALID  = 1'b0;
    logic [3:0]  RTE_FORMAT = 4'h0;
    logic        DEC_DONE, EXC_VALID, CACHE_VALID, CACHE_PUSH, CR_HIT;
    logic        UNDEF_OP, RTE_DONE, RTE_ERROR;
    logic [7:0]  EXC_VECTOR;
    logic [3:0]  EXC_FORMAT;
    logic [1:0]  CACHE_SCOPE;
    logic [2:0]  CR_SEL;
    logic [31:0] CACHE_BASE, CR_RDATA;
    int          mismatches = 0;
    int          compares   = 0;
    logic [31:0] rnd        = 32'hbca1_8988;
    logic [31:0] mdl [6];
    logic [11:0] enc [6];
    logic [15:0] w;
    int          k;

    // Free-running core clock, 5 ns period.
    always #2.5 CLK = ~CLK;

    rcoc_decoder rcoc_decoder_inst (
        .CLK(CLK), .SRST(SRST), .OP_VALID(OP_VALID), .OP_WORD(OP_WORD),
        .OP_EXT(OP_EXT), .OP_DATA(OP_DATA), .RTE_VALID(RTE_VALID),
        .RTE_FORMAT(RTE_FORMAT), .DEC_DONE(DEC_DONE), .EXC_VALID(EXC_VALID),
        .EXC_VECTOR(EXC_VECTOR), .EXC_FORMAT(EXC_FORMAT), .CACHE_VALID(CACHE_VALID),
        .CACHE_PUSH(CACHE_PUSH), .CACHE_SCOPE(CACHE_SCOPE), .CACHE_BASE(CACHE_BASE),
        .CR_HIT(CR_HIT), .CR_SEL(CR_SEL), .CR_RDATA(CR_RDATA), .UNDEF_OP(UNDEF_OP),
        .RTE_DONE(RTE_DONE), .RTE_ERROR(RTE_ERROR)
    );

    // ------------------------------------------------------------------------
    // Expectation helpers.
    // ------------------------------------------------------------------------
    // Maximal-length feedback taps keep the random sequence from repeating early.
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    // Base address that a cache request of the given scope must carry.
    function automatic logic [31:0] exp_base(input logic [1:0] sc, input logic [31:0] d);
        case (sc)
            2'b01:   return d & `RCOC_LINE_MASK;
            2'b10:   return d & `RCOC_PAGE_MASK;
            default: return 32'h0000_0000;
        endcase
    endfunction

    // Return frames outside the accepted set must be flagged.
    function automatic logic rte_bad(input logic [3:0] f);
        return !(f inside {4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h7});
    endfunction

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH at %0t: saw %h, expected %h", $time, got, exp);
        end
    endtask

    // One opcode, optionally with a return frame, then one idle cycle.
    // Results are registered, so they are looked at just after the answer edge.
    task automatic op(input logic [15:0] wd, input logic [15:0] ex, input logic [31:0] d,
                      input logic rv, input logic [3:0] rf);
        @(posedge CLK);
        OP_VALID   <= 1'b1;
        OP_WORD    <= wd;
        OP_EXT     <= ex;
        OP_DATA    <= d;
        RTE_VALID  <= rv;
        RTE_FORMAT <= rf;
        @(posedge CLK);
        OP_VALID  <= 1'b0;
        RTE_VALID <= 1'b0;
        #1;
        check(DEC_DONE, 1'b1);
    endtask

    // Reads every stored register and compares it with the model.
    task automatic readall();
        for (int i = 0; i < 6; i++) begin
            op(16'h4E7A, {4'h0, enc[i]}, lfsr(rnd), 1'b0, 4'h0);
            check({CR_HIT, CR_SEL}, {1'b1, i[2:0]});
            check(CR_RDATA, mdl[i]);
        end
    endtask

    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------------
    // Main sequence.
    // ------------------------------------------------------------------------
    // The whole run needs well under two thousand cycles; a hang trips this.
    initial begin
        repeat (20000) @(posedge CLK);
        mismatches++;
        conclude();
    end

    initial begin
        enc = '{`RCOC_CR_TC, `RCOC_CR_STATUS, `RCOC_CR_IWIN0,
                `RCOC_CR_IWIN1, `RCOC_CR_DWIN0, `RCOC_CR_DWIN1};
        foreach (mdl[i]) mdl[i] = 32'h0000_0000;
        repeat (20) @(posedge CLK);
        SRST <= 1'b0;
        #1;
        check({DEC_DONE, EXC_VALID, CACHE_VALID, CR_HIT, UNDEF_OP, RTE_DONE}, 32'h0);
        readall();
        // Page push corner: an address just below a page boundary lands on its base.
        // Bit 5 selects push, so the opcode carries it to exercise that path.
        op(16'hF4F0, 16'h0000, 32'h1234_5FFF, 1'b0, 4'h0);
        check(CACHE_BASE, 32'h1234_5000);
        check({CACHE_VALID, CACHE_PUSH, CACHE_SCOPE}, 4'b1110);
        repeat (40) begin
            rnd = lfsr(rnd);
            // Floating point opcode with a random return frame alongside.
            op(16'hF200 | {7'h0, rnd[8:0]}, rnd[31:16], rnd, 1'b1, rnd[12:9]);
            check({EXC_VALID, EXC_VECTOR, EXC_FORMAT}, {1'b1, 8'h0B, 4'h4});
            check(EXC_FORMAT == 4'h3, 1'b0);
            check({RTE_DONE, RTE_ERROR}, {1'b1, rte_bad(rnd[12:9])});
            // Probe and flush variants decode quietly.
            op(16'hF548 | (rnd[15:0] & 16'h0027), 16'h0000, rnd, 1'b0, 4'h0);
            check({EXC_VALID, UNDEF_OP, CACHE_VALID, CR_HIT}, 4'b0100);
            op(16'hF500 | (rnd[15:0] & 16'h001F), 16'h0000, rnd, 1'b0, 4'h0);
            check({EXC_VALID, UNDEF_OP, CACHE_VALID, CR_HIT}, 4'b0100);
            // Cache maintenance with random push bit, scope and address.
            w = 16'hF400 | {8'h00, rnd[23:16]};
            op(w, 16'h0000, rnd, 1'b0, 4'h0);
            if (w[4:3] != 2'b00) begin
                check({CACHE_VALID, CACHE_PUSH, CACHE_SCOPE}, {1'b1, w[5], w[4:3]});
                check(CACHE_BASE, exp_base(w[4:3], rnd));
            end else begin
                check({CACHE_VALID, EXC_VALID}, 2'b00);
            end
            // Register write returns the old contents.
            k = rnd[26:24] % 6;
            rnd = lfsr(rnd);
            op(16'h4E7B, {4'h0, enc[k]}, rnd, 1'b0, 4'h0);
            check({CR_HIT, CR_SEL, EXC_VALID}, {1'b1, k[2:0], 1'b0});
            check(CR_RDATA, mdl[k]);
            mdl[k] = rnd;
        end
        // Back-to-back write then read: the read must see the new value.
        for (int i = 0; i < 6; i++) begin
            @(posedge CLK);
            OP_VALID <= 1'b1;
            OP_WORD  <= 16'h4E7B;
            OP_EXT   <= {4'h0, enc[i]};
            OP_DATA  <= ~mdl[i];
            @(posedge CLK);
            OP_WORD <= 16'h4E7A;
            #1;
            check(CR_RDATA, mdl[i]);
            mdl[i] = ~mdl[i];
            @(posedge CLK);
            OP_VALID <= 1'b0;
            #1;
            check({CR_HIT, CR_SEL}, {1'b1, i[2:0]});
            check(CR_RDATA, mdl[i]);
        end
        // Root pointer moves and an unmapped encoding leave storage alone.
        foreach (enc[i]) begin
            op(16'h4E7A | {15'h0, i[0]}, {4'h0, `RCOC_CR_UROOT} | {15'h0, i[1]}, 32'hA5A5_5A5A,
               1'b0, 4'h0);
            check({CR_HIT, EXC_VALID, UNDEF_OP}, 3'b001);
        end
        op(16'h4E7B, 16'h0002, 32'h1234_5678, 1'b0, 4'h0);
        check({CR_HIT, EXC_VALID, UNDEF_OP}, 3'b000);
        readall();
        // Every return format, with an ordinary opcode beside it.
        for (int f = 0; f < 16; f++) begin
            op(16'h4E71, 16'h0000, 32'h0, 1'b1, f[3:0]);
            check({RTE_DONE, RTE_ERROR}, {1'b1, rte_bad(f[3:0])});
            check({EXC_VALID, EXC_FORMAT}, 5'h00);
        end
        // A second reset in mid-run must clear the stored registers.
        @(posedge CLK);
        SRST <= 1'b1;
        @(posedge CLK);
        SRST <= 1'b0;
        foreach (mdl[i]) mdl[i] = 32'h0000_0000;
        readall();
        conclude();
    end
endmodule
